// ### verilog/fir_core.sv
// fault injection and recovery logic of one load converter unit
`timescale 1ns/1ns
`include "fir_map.svh"
module fir_core
  import fir_pkg::*;
#(
  parameter int NF = `FIR_NFAULT,
  parameter int NG = `FIR_NGROUP,
  parameter int HICCUP_CYC = `FIR_HICCUP_CYC
)
(
  input wire logic clk,
  input wire logic rst,
  input wire fir_pkg::fir_fault_in_t faultIn,
  input wire logic [NF-1:0] latchingType,
  input wire fir_pkg::fir_cmd_t mgrCmd,
  input wire logic enablePin,
  input wire logic [NG-1:0] myGroup,
  input wire logic [NG-1:0] propagateTo,
  input wire logic [NG-1:0] groupFaultIn,
  input wire logic syncDataIn,
  output logic [NG-1:0] groupFaultOut_r,
  output logic outputOn_r,
  output logic [NF-1:0] faultStatus_r,
  output logic switchSync_r
);
  import fir_pkg::*;

  // ==========================================
  // fault qualification
  logic [NF-1:0] effFault;
  logic [NF-1:0] latchHit;
  logic localFault;
  logic groupFault;
  logic anyLatching;
  logic enPrev_r;
  logic enFall;
  logic hiccupDone;
  logic [31:0] hiccupCnt_r;
  fir_state_t state_r;
  fir_state_t state_nxt;

  // injection and detection are merged before anything else sees them
  genvar gi;
  generate
    for (gi = 0; gi < NF; gi++)
    begin : g_qual
      assign effFault[gi] = faultIn.detect[gi] | faultIn.inject[gi];
      assign latchHit[gi] = effFault[gi] & latchingType[gi];
    end
  endgenerate

  assign localFault = |effFault;
  // only lines of our own group shut us down; foreign groups keep us running
  assign groupFault = |(groupFaultIn & myGroup);
  assign anyLatching = |latchHit;
  assign enFall = enPrev_r & ~enablePin;
  // compare rather than equal so a shortened parameter cannot skip the end
  assign hiccupDone = (hiccupCnt_r >= 32'(HICCUP_CYC - 1));

  // ==========================================
  // status and propagation
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      faultStatus_r <= '0;
    end
    else
    begin
      faultStatus_r <= effFault;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      groupFaultOut_r <= '0;
    end
    else if (localFault)
    begin
      groupFaultOut_r <= myGroup | propagateTo;
    end
    else
    begin
      groupFaultOut_r <= '0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enPrev_r <= 1'b0;
    end
    else
    begin
      enPrev_r <= enablePin;
    end
  end

  // ==========================================
  // sync data line
  // switching sync recovered from the shared line; data decode lives elsewhere
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      switchSync_r <= 1'b0;
    end
    else
    begin
      switchSync_r <= syncDataIn;
    end
  end

  // ==========================================
  // recovery state machine
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      FIR_RUN:
      begin
        if (localFault && anyLatching)
        begin
          state_nxt = FIR_LATCHED;
        end
        else if (localFault || groupFault)
        begin
          state_nxt = FIR_HICCUP;
        end
        else if (mgrCmd.off || !enablePin)
        begin
          state_nxt = FIR_OFF;
        end
      end
      FIR_HICCUP:
      begin
        if (localFault && anyLatching)
        begin
          state_nxt = FIR_LATCHED;
        end
        else if (localFault || groupFault)
        begin
          state_nxt = FIR_HICCUP;
        end
        else if (mgrCmd.off || !enablePin)
        begin
          state_nxt = FIR_OFF;
        end
        else if (hiccupDone)
        begin
          state_nxt = FIR_RUN;
        end
      end
      FIR_LATCHED:
      begin
        // fault wins: a clear while the trigger is still up is ignored
        if ((mgrCmd.off || enFall) && !localFault)
        begin
          state_nxt = FIR_OFF;
        end
      end
      FIR_OFF:
      begin
        if (mgrCmd.on && !mgrCmd.off && enablePin && !localFault && !groupFault)
        begin
          state_nxt = FIR_RUN;
        end
      end
      default:
      begin
        state_nxt = FIR_OFF;
      end
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= FIR_OFF;
    end
    else
    begin
      state_r <= state_nxt;
    end
  end

  // ==========================================
  // hiccup timer
  // restarts while any fault persists, so the wait counts from the clear
  always_ff @(posedge clk)
  begin
    if (rst || state_r != FIR_HICCUP || localFault || groupFault)
    begin
      hiccupCnt_r <= '0;
    end
    else
    begin
      hiccupCnt_r <= hiccupCnt_r + 32'h1;
    end
  end

  // ==========================================
  // output enable
  // taken from the next state so the output reacts one cycle after the cause
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      outputOn_r <= 1'b0;
    end
    else
    begin
      outputOn_r <= (state_nxt == FIR_RUN);
    end
  end
endmodule // fir_core

// ### verilog/fir_map.svh
// constants of the fault injection and recovery block
`ifndef FIR_MAP_SVH
`define FIR_MAP_SVH
`define FIR_CLK_HZ 25000000
`define FIR_HICCUP_MS 130
`define FIR_HICCUP_CYC ((`FIR_CLK_HZ / 1000) * `FIR_HICCUP_MS)
`define FIR_NFAULT 4
`define FIR_NGROUP 4
`define FIR_FT_OT 0
`endif

// ### verilog/fir_pkg.sv
// types of the fault injection and recovery block
package fir_pkg;
  typedef struct packed {
    logic [3:0] detect;
    logic [3:0] inject;
  } fir_fault_in_t;
  typedef struct packed {
    logic on;
    logic off;
  } fir_cmd_t;
  typedef enum logic [3:0] {
    FIR_RUN = 4'h1,
    FIR_HICCUP = 4'h2,
    FIR_LATCHED = 4'h4,
    FIR_OFF = 4'h8
  } fir_state_t;
endpackage

// ### tb/fir_core_properties.sv
// checker of the fault injection block ports
`timescale 1ns/1ns
module fir_core_properties
  import fir_pkg::*;
#(
  parameter int NF = 4,
  parameter int NG = 4
)
(
  input wire logic clk,
  input wire logic rst,
  input wire fir_pkg::fir_fault_in_t faultIn,
  input wire logic [NF-1:0] latchingType,
  input wire fir_pkg::fir_cmd_t mgrCmd,
  input wire logic [NG-1:0] myGroup,
  input wire logic [NG-1:0] propagateTo,
  input wire logic syncDataIn,
  input wire logic [NG-1:0] groupFaultOut_r,
  input wire logic outputOn_r,
  input wire logic [NF-1:0] faultStatus_r,
  input wire logic switchSync_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [NF-1:0] eff;
  assign eff = faultIn.detect[NF-1:0] | faultIn.inject[NF-1:0];
  AST_SYN: assert property (!$past(rst) |-> switchSync_r == $past(syncDataIn))
    else $error("sync copy wrong");
  AST_STA: assert property (!$past(rst) |-> faultStatus_r == $past(eff))
    else $error("status wrong");
  AST_INJ: assert property (|faultIn.inject |=> !outputOn_r)
    else $error("output on during injection");
  AST_DET: assert property (|faultIn.detect |=> !outputOn_r)
    else $error("output on during fault");
  AST_GRP: assert property (|eff |=> groupFaultOut_r == $past(myGroup | propagateTo))
    else $error("group lines wrong");
  AST_CLR: assert property (eff == '0 |=> groupFaultOut_r == '0)
    else $error("group lines not cleared");
  AST_OFF: assert property (mgrCmd.off |=> !outputOn_r)
    else $error("output on after off");
  AST_LAT: assert property (|(eff & latchingType) ##1 (mgrCmd == 2'h0)[*8] |-> !outputOn_r)
    else $error("latched fault restarted");
  cover property ($rose(outputOn_r));
  cover property (|groupFaultOut_r);
  cover property (|(faultStatus_r & latchingType));
  cover property (mgrCmd.off ##1 !outputOn_r);
endmodule // fir_core_properties
bind fir_core fir_core_properties u_fir_core_properties (.*);

// ### tb/fir_mgr_model.sv
// manager model: command pulses and sync line
`timescale 1ns/1ns
module fir_mgr_model
  import fir_pkg::*;
(
  input wire logic clk,
  input wire logic onReq,
  input wire logic offReq,
  output fir_pkg::fir_cmd_t mgrCmd,
  output logic syncDataIn
);
  initial mgrCmd = 2'h0;
  initial syncDataIn = 1'b0;
  always @(posedge clk) mgrCmd <= {onReq, offReq};
  always @(posedge clk) syncDataIn <= ~syncDataIn;
endmodule // fir_mgr_model

// ### tb/test_fir_core.sv
// testbench of the fault injection block
`timescale 1ns/1ns
module test_fir_core;
  import fir_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic onReq = 1'b0;
  logic offReq = 1'b0;
  logic en = 1'b1;
  logic on;
  logic sw;
  logic sd;
  fir_fault_in_t fi = 8'h00;
  fir_cmd_t cmd;
  logic [3:0] lt = 4'h0;
  logic [3:0] prop = 4'h0;
  logic [3:0] gIn = 4'h0;
  logic [3:0] gOut;
  logic [3:0] st;
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  // row: fault inputs, propagation, expected group lines, expected status
  logic [19:0] rows [4] = '{20'h01011, 20'h02232, 20'h04454, 20'h10011};
  fir_core #(.HICCUP_CYC(20)) u_fir_core (.clk(clk), .rst(rst), .faultIn(fi), .latchingType(lt),
    .mgrCmd(cmd), .enablePin(en), .myGroup(4'h1), .propagateTo(prop), .groupFaultIn(gIn),
    .syncDataIn(sd), .groupFaultOut_r(gOut), .outputOn_r(on), .faultStatus_r(st),
    .switchSync_r(sw));
  fir_mgr_model u_fir_mgr_model (.clk(clk), .onReq(onReq), .offReq(offReq), .mgrCmd(cmd),
    .syncDataIn(sd));
  initial forever #20 clk = ~clk;
  task automatic t(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic pulse_on;
    onReq = 1'b1;
    t(1);
    onReq = 1'b0;
    t(2);
  endtask
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    cmp_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task close_out;
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      n_errors++;
      close_out;
    end
  end
  initial
  begin
    t(20);
    rst = 1'b0;
    chk(on, 4'h0);
    chk(gOut, 4'h0);
    pulse_on;
    chk(on, 4'h1);
    chk({3'h0, sw}, {3'h0, ~sd});
    $display("reset test done");
    foreach (rows[i])
    begin
      fi = rows[i][19:12];
      prop = rows[i][11:8];
      t(2);
      chk(on, 4'h0);
      chk(gOut, rows[i][7:4]);
      chk(st, rows[i][3:0]);
      fi = 8'h00;
      t(10);
      chk(on, 4'h0);
      chk(gOut, 4'h0);
      t(20);
      chk(on, 4'h1);
      $display("row %0d done", i);
    end
    lt = 4'h1;
    fi.inject = 4'h1;
    t(2);
    fi = 8'h00;
    t(30);
    chk(on, 4'h0);
    offReq = 1'b1;
    t(1);
    offReq = 1'b0;
    pulse_on;
    chk(on, 4'h1);
    $display("latch off test done");
    fi.detect = 4'h1;
    t(2);
    fi = 8'h00;
    t(5);
    chk(on, 4'h0);
    en = 1'b0;
    t(2);
    en = 1'b1;
    t(2);
    chk(on, 4'h0);
    pulse_on;
    chk(on, 4'h1);
    $display("latch enable test done");
    lt = 4'h0;
    gIn = 4'h2;
    t(2);
    chk(on, 4'h1);
    gIn = 4'h1;
    t(2);
    chk(on, 4'h0);
    chk(gOut, 4'h0);
    gIn = 4'h0;
    t(22);
    chk(on, 4'h1);
    $display("group test done");
    rst = 1'b1;
    t(2);
    chk(on, 4'h0);
    chk(st, 4'h0);
    rst = 1'b0;
    t(1);
    chk(on, 4'h0);
    $display("second reset test done");
    close_out;
  end
endmodule // test_fir_core
